// ===== hw/adcr_map.svh
`ifndef ADCR_MAP_SVH
`define ADCR_MAP_SVH

// ==========================================================
// register select codes carried in the command byte
`define ADCR_RS_RESULT 3'h3
`define ADCR_RS_ID 3'h4
`define ADCR_RS_GPO 3'h5

// ==========================================================
// reset values
`define ADCR_RESULT_RST 24'h000000
`define ADCR_GPO_RST 8'h00
`define ADCR_TAG_RST 4'h0

// ==========================================================
// command byte fields
`define ADCR_COMM_WEN_B 7
`define ADCR_COMM_RD 6
`define ADCR_COMM_RS_HI 5
`define ADCR_COMM_RS_LO 3

// ==========================================================
// output control fields
`define ADCR_GPO_UPPER_EN 5
`define ADCR_GPO_LOWER_EN 4

// ==========================================================
// channel select fields
`define ADCR_CH_POS_HI 7
`define ADCR_CH_POS_LO 4
`define ADCR_CH_NEG_HI 3
`define ADCR_CH_NEG_LO 0

// ==========================================================
// frame lengths in serial clock periods
`define ADCR_BYTE_BITS 6'h08
`define ADCR_RESULT_BITS 6'h18
`define ADCR_APPEND_BITS 6'h20

`endif

// ===== hw/adcr_pkg.sv
// ==========================================================
// shared types of the result, identification and output block
package adcr_pkg;

  // serial frame sequencer states
  typedef enum logic [1:0] {
    ADCR_IDLE = 2'b00,  // chip select high
    ADCR_COMM = 2'b01,  // shifting in a command byte
    ADCR_DATA = 2'b10   // data phase of the selected register
  } adcr_state_t;

  // register select code
  typedef logic [2:0] adcr_rs_t;

endpackage

// ===== hw/adcr_gpo_if.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// link between the register sequencer and the pin logic
interface adcr_gpo_if;
  logic [7:0] ctrl;    // stored output control register
  logic [7:0] rd_val;  // value returned when the register is read

  modport reg_side (output ctrl, input rd_val);
  modport pin_side (input ctrl, output rd_val);
endinterface

`default_nettype wire

// ===== hw/adcr_gpo.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcr_map.svh"

// ==========================================================
// general purpose output pins and their shared analog roles
module adcr_gpo (
  input wire logic mclk,                    // master clock
  input wire logic rst_b,                   // async reset, active low
  adcr_gpo_if.pin_side gif,                 // control from the register side
  input wire logic reference_source_select, // second reference chosen
  input wire logic [3:0] gp_i,              // pin levels seen at the pads
  output logic [3:0] gp_o,                  // pin drive levels
  output logic [3:0] gp_oe,                 // pin drive enables
  output logic upper_pair_analog,           // pins three, two are inputs 1, 2
  output logic lower_pair_ref2,             // pins one, zero are second reference
  output logic lower_pair_analog            // pins one, zero are inputs 3, 4
);

  logic upper_en;      // enable of pins three and two
  logic lower_en;      // enable of pins one and zero
  logic [3:0] pin_en;  // per pin enable
  logic [3:0] gp_o_d;
  logic [3:0] gp_oe_d;
  logic [2:0] role_d;
  logic [3:0] gp_o_q;
  logic [3:0] gp_oe_q;
  logic [2:0] role_q;

  assign upper_en = gif.ctrl[`ADCR_GPO_UPPER_EN];
  assign lower_en = gif.ctrl[`ADCR_GPO_LOWER_EN];
  assign pin_en = {upper_en, upper_en, lower_en, lower_en};

  // ==========================================================
  // readback, one bit per pin
  assign gif.rd_val[7:4] = gif.ctrl[7:4];
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_rd
      assign gif.rd_val[i] = pin_en[i] ? gp_i[i] : gif.ctrl[i];
    end
  endgenerate

  // ==========================================================
  // next pin drive and pin role
  always_comb begin
    // data bits drive pins
    // disabled pins drive low so their data bits have no effect
    gp_o_d = gif.ctrl[3:0] & pin_en;
    gp_oe_d = pin_en;
    role_d[2] = ~upper_en;
    role_d[1] = ~lower_en & reference_source_select;
    role_d[0] = ~lower_en & ~reference_source_select;
  end

  // registered so every pin output comes from a flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gp_o_q <= 4'h0;
      gp_oe_q <= 4'h0;
      role_q <= 3'h7;
    end else begin
      gp_o_q <= gp_o_d;
      gp_oe_q <= gp_oe_d;
      role_q <= role_d;
    end
  end

  assign gp_o = gp_o_q;
  assign gp_oe = gp_oe_q;
  assign upper_pair_analog = role_q[2];
  assign lower_pair_ref2 = role_q[1];
  assign lower_pair_analog = role_q[0];

endmodule

`default_nettype wire

// ===== hw/adcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcr_map.svh"


// ==========================================================
// serial register slave for result, identification and outputs
module adcr_regs #(
  parameter logic [7:0] PART_ID = 8'h5a  // arbitrary identification value
) (
  input wire logic mclk,                    // master clock, 25 MHz
  input wire logic rst_b,                   // async reset, active low
  input wire logic sclk,                    // serial clock, idles high
  input wire logic cs_b,                    // serial chip select, active low
  input wire logic din,                     // serial data in
  output logic dout,                        // serial data out
  output logic rdy_b,                       // data ready pin, low when ready
  input wire logic conv_done,               // one-cycle conversion complete
  input wire logic [23:0] conv_data,        // new conversion word
  input wire logic [7:0] chan_sel,          // channel select bits seven..zero
  input wire logic pseudo_en,               // pseudo differential option
  input wire logic status_append_enable,    // append status to result reads
  input wire logic reference_source_select, // second reference chosen
  input wire logic [3:0] gp_i,              // output pin levels at the pads
  output logic [3:0] gp_o,                  // output pin drive levels
  output logic [3:0] gp_oe,                 // output pin drive enables
  output logic [3:0] pos_input_sel,         // positive input, 0 means input 1
  output logic [3:0] neg_input_sel,         // negative input when not common
  output logic neg_input_common,            // negative input is common input
  output logic [3:0] result_channel_tag,    // channel of the held result
  output logic upper_pair_analog,           // pins three, two are analog
  output logic lower_pair_ref2,             // pins one, zero second reference
  output logic lower_pair_analog            // pins one, zero are analog
);

  // ==========================================================
  // declarations
  adcr_gpo_if gif ();  // link to the pin logic

  adcr_pkg::adcr_state_t state_q;  // frame sequencer state
  adcr_pkg::adcr_state_t state_d;
  logic [5:0] cnt_q;               // bits done in current phase
  logic [5:0] cnt_d;
  logic [5:0] len_q;               // data phase length in bits
  logic [5:0] len_d;
  logic rd_q;                      // current frame is a read
  logic rd_d;
  adcr_pkg::adcr_rs_t rs_q;        // current register select code
  adcr_pkg::adcr_rs_t rs_d;
  logic [6:0] comm_q;              // command bits gathered so far
  logic [6:0] comm_d;
  logic [31:0] sh_q;               // data shifter, msb leaves first
  logic [31:0] sh_d;
  logic dout_q;                    // serial output flop
  logic dout_d;
  logic sclk_q;                    // serial clock one cycle ago
  logic sclk_rise;                 // host samples out, we sample din
  logic sclk_fall;                 // we present the next out bit

  logic [23:0] result_q;           // held conversion result
  logic [23:0] result_d;
  logic [3:0] tag_q;               // channel of the held result
  logic [3:0] tag_d;
  logic rdy_q;                     // high while no unread result
  logic rdy_d;
  logic [7:0] gpo_q;               // output control register
  logic [7:0] gpo_d;

  logic [7:0] cbyte;               // full command byte on its last bit
  adcr_pkg::adcr_rs_t cbyte_rs;    // register select of that byte
  logic [7:0] status_val;          // status byte as appended
  logic last_bit;                  // final data bit of the frame
  logic rd_done;                   // a result read just finished

  logic [3:0] pos_d;
  logic [3:0] neg_d;
  logic negc_d;
  logic [3:0] pos_q;
  logic [3:0] neg_q;
  logic negc_q;

  // ==========================================================
  // serial clock edges; inputs are already synchronous to mclk
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;

  // ==========================================================
  // combinational helpers
  assign cbyte = {comm_q, din};
  assign cbyte_rs = cbyte[`ADCR_COMM_RS_HI:`ADCR_COMM_RS_LO];
  // channel tag in status
  // ready flag in bit 7; bits 6..4 belong to another block and read as zero here
  assign status_val = {rdy_q, 3'h0, tag_q};
  assign last_bit = (cnt_q == len_q - 6'h01);
  assign gif.ctrl = gpo_q;

  // ==========================================================
  // next state of the serial frame sequencer and registers
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    len_d = len_q;
    rd_d = rd_q;
    rs_d = rs_q;
    comm_d = comm_q;
    sh_d = sh_q;
    dout_d = dout_q;
    result_d = result_q;
    tag_d = tag_q;
    rdy_d = rdy_q;
    gpo_d = gpo_q;
    rd_done = 1'b0;
    if (cs_b) begin
      // deselect aborts any frame; a half-written byte is dropped
      state_d = adcr_pkg::ADCR_IDLE;
      cnt_d = 6'h00;
      dout_d = 1'b0;
    end else begin
      unique case (state_q)
        adcr_pkg::ADCR_IDLE: begin
          state_d = adcr_pkg::ADCR_COMM;
          cnt_d = 6'h00;
        end
        adcr_pkg::ADCR_COMM: begin
          if (sclk_rise) begin
            comm_d = cbyte[6:0];
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == `ADCR_BYTE_BITS - 6'h01) begin
              cnt_d = 6'h00;
              // a byte with its leading bit set is not a command
              if (!cbyte[`ADCR_COMM_WEN_B]) begin
                state_d = adcr_pkg::ADCR_DATA;
                rd_d = cbyte[`ADCR_COMM_RD];
                rs_d = cbyte_rs;
                sh_d = 32'h00000000;
                len_d = `ADCR_BYTE_BITS;
                unique case (cbyte_rs)
                  `ADCR_RS_RESULT: begin
                    if (status_append_enable) begin
                      len_d = `ADCR_APPEND_BITS;
                      sh_d = {result_q, status_val};
                    end else begin
                      len_d = `ADCR_RESULT_BITS;
                      sh_d = {result_q, 8'h00};
                    end
                  end
                  `ADCR_RS_ID: begin
                    sh_d = {PART_ID, 24'h000000};
                  end
                  `ADCR_RS_GPO: begin
                    sh_d = {gif.rd_val, 24'h000000};
                  end
                  default: begin
                    // codes held by other blocks read as zero here
                    sh_d = 32'h00000000;
                  end
                endcase
              end
            end
          end
        end
        adcr_pkg::ADCR_DATA: begin
          if (sclk_fall && rd_q) begin
            // present next bit while sclk is low, msb first
            dout_d = sh_q[31];
            sh_d = {sh_q[30:0], 1'b0};
          end
          if (sclk_rise) begin
            cnt_d = cnt_q + 6'h01;
            if (!rd_q) begin
              sh_d = {sh_q[30:0], din};
            end
            if (last_bit) begin
              state_d = adcr_pkg::ADCR_COMM;
              cnt_d = 6'h00;
              // first bit lands in bit 7
              // bits 7, 6 stored as sent
              if (!rd_q && rs_q == `ADCR_RS_GPO) begin
                gpo_d = {sh_q[6:0], din};
              end
              if (rd_q && rs_q == `ADCR_RS_RESULT) begin
                rd_done = 1'b1;
                rdy_d = 1'b1;
              end
            end
          end
        end
        default: begin
          state_d = adcr_pkg::ADCR_IDLE;
        end
      endcase
    end
    // held until next conversion
    // a conversion in the same cycle as a finished read wins, so it is not lost
    if (conv_done) begin
      result_d = conv_data;
      tag_d = chan_sel[`ADCR_CH_POS_HI:`ADCR_CH_POS_LO];
      rdy_d = 1'b0;
    end
  end

  // ==========================================================
  // frame and register flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= adcr_pkg::ADCR_IDLE;
      cnt_q <= 6'h00;
      len_q <= `ADCR_BYTE_BITS;
      rd_q <= 1'b0;
      rs_q <= 3'h0;
      comm_q <= 7'h00;
      sh_q <= 32'h00000000;
      dout_q <= 1'b0;
      result_q <= `ADCR_RESULT_RST;
      tag_q <= `ADCR_TAG_RST;
      rdy_q <= 1'b1;
      gpo_q <= `ADCR_GPO_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      rd_q <= rd_d;
      rs_q <= rs_d;
      comm_q <= comm_d;
      sh_q <= sh_d;
      dout_q <= dout_d;
      result_q <= result_d;
      tag_q <= tag_d;
      rdy_q <= rdy_d;
      gpo_q <= gpo_d;
    end
  end

  // ==========================================================
  // channel decode for the multiplexer
  always_comb begin
    pos_d = chan_sel[`ADCR_CH_POS_HI:`ADCR_CH_POS_LO];
    // lower bits only matter when the option is off
    neg_d = pseudo_en ? 4'h0 : chan_sel[`ADCR_CH_NEG_HI:`ADCR_CH_NEG_LO];
    negc_d = pseudo_en;
  end

  // registered to keep the mux select glitch free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pos_q <= 4'h0;
      neg_q <= 4'h0;
      negc_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      neg_q <= neg_d;
      negc_q <= negc_d;
    end
  end

  // ==========================================================
  // pin logic
  adcr_gpo u_gpo (
    .mclk(mclk),
    .rst_b(rst_b),
    .gif(gif),
    .reference_source_select(reference_source_select),
    .gp_i(gp_i),
    .gp_o(gp_o),
    .gp_oe(gp_oe),
    .upper_pair_analog(upper_pair_analog),
    .lower_pair_ref2(lower_pair_ref2),
    .lower_pair_analog(lower_pair_analog)
  );

  // ==========================================================
  // outputs straight from flops
  assign dout = dout_q;
  assign rdy_b = rdy_q;
  assign pos_input_sel = pos_q;
  assign neg_input_sel = neg_q;
  assign neg_input_common = negc_q;
  assign result_channel_tag = tag_q;

endmodule

`default_nettype wire

// ===== dv/adcr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port level checks of the result, identification and output block
module adcr_regs_chk (
  input wire logic mclk,                    // master clock
  input wire logic rst_b,                   // async reset, active low
  input wire logic rdy_b,                   // data ready pin
  input wire logic conv_done,               // conversion complete pulse
  input wire logic [7:0] chan_sel,          // channel select bits
  input wire logic pseudo_en,               // pseudo differential option
  input wire logic reference_source_select, // second reference chosen
  input wire logic [3:0] gp_o,              // pin drive levels
  input wire logic [3:0] gp_oe,             // pin drive enables
  input wire logic [3:0] pos_input_sel,     // positive input
  input wire logic [3:0] neg_input_sel,     // negative input
  input wire logic neg_input_common,        // negative input is common
  input wire logic [3:0] result_channel_tag,// channel of held result
  input wire logic upper_pair_analog,       // pins three, two analog
  input wire logic lower_pair_ref2,         // pins one, zero reference
  input wire logic lower_pair_analog        // pins one, zero analog
);
  logic [3:0] chan_pos; // upper select bits, kept apart so $past sees a plain signal
  assign chan_pos = chan_sel[7:4];

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // decode and result tagging
  chk_pos_follow: assert property ($past(rst_b) |-> pos_input_sel == $past(chan_pos))
    else $error("positive input select does not follow the upper bits");
  chk_neg_common: assert property ($past(rst_b) && $past(pseudo_en) |-> neg_input_common && neg_input_sel == 4'h0)
    else $error("negative input not common in pseudo mode");
  chk_tag_capture: assert property (conv_done |=> result_channel_tag == $past(chan_pos))
    else $error("result tag not taken from the channel bits");
  chk_tag_hold: assert property (!conv_done |=> $stable(result_channel_tag))
    else $error("result tag moved without a conversion");
  chk_ready_set: assert property (conv_done |=> !rdy_b)
    else $error("ready not shown after a conversion");

  // ==========================================================
  // pin roles; the pairs must always switch together
  chk_pair_enables: assert property (gp_oe[3] == gp_oe[2] && gp_oe[1] == gp_oe[0])
    else $error("pin enables not paired");
  chk_off_quiet: assert property ((gp_o & ~gp_oe) == 4'h0)
    else $error("disabled pin carries a level");
  chk_upper_roles: assert property (upper_pair_analog == !gp_oe[3])
    else $error("upper pair role wrong");
  chk_lower_roles: assert property ($past(rst_b) |-> lower_pair_ref2 == (!gp_oe[0] && $past(reference_source_select))
    && lower_pair_analog == (!gp_oe[0] && !$past(reference_source_select)))
    else $error("lower pair role wrong");

  cover property (conv_done);
  cover property (gp_oe == 4'hf);
  cover property (lower_pair_ref2);
endmodule

bind adcr_regs adcr_regs_chk u_adcr_regs_chk (.mclk(mclk), .rst_b(rst_b), .rdy_b(rdy_b), .conv_done(conv_done),
  .chan_sel(chan_sel), .pseudo_en(pseudo_en), .reference_source_select(reference_source_select), .gp_o(gp_o),
  .gp_oe(gp_oe), .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel), .neg_input_common(neg_input_common),
  .result_channel_tag(result_channel_tag), .upper_pair_analog(upper_pair_analog),
  .lower_pair_ref2(lower_pair_ref2), .lower_pair_analog(lower_pair_analog));

`default_nettype wire

// ===== dv/adcr_host.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// host controller on the serial port
module adcr_host (
  input wire logic mclk,  // master clock
  output logic sclk,      // serial clock, idles high
  output logic cs_b,      // chip select, active low
  output logic din,       // data to the device
  input wire logic dout   // data from the device
);
  initial begin
    sclk = 1'b1;
    cs_b = 1'b1;
    din = 1'b0;
  end

  // one frame: command byte then n data bits; three mclk per phase keeps both phases legal
  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] bits;
    bits = {cmd, wd << (32 - n)};
    rd = 32'h0;
    @(posedge mclk);
    #1 cs_b = 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 8 + n; i++) begin
      @(posedge mclk);
      #1 sclk = 1'b0;
      din = bits[39 - i];
      repeat (3) @(posedge mclk);
      if (i >= 8) begin
        rd = {rd[30:0], dout};
      end
      #1 sclk = 1'b1;
      repeat (2) @(posedge mclk);
    end
    @(posedge mclk);
    // released data line flips so a stale level is never mistaken for data
    #1 cs_b = 1'b1;
    din = ~din;
  endtask
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// self checking bench of the result, identification and output block
module tb_top;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identification value
  logic mclk, rst_b, conv_done, pseudo_en, status_append_enable, reference_source_select;
  logic [23:0] conv_data;
  logic [7:0] chan_sel;
  logic [3:0] ext_i; // level the outside world puts on undriven pins
  logic fight; // an outside driver overpowers even the driven pins
  logic [31:0] rd;
  wire logic sclk, cs_b, din, dout, rdy_b, ncom, upa, lr2, lan;
  wire logic [3:0] gp_o, gp_oe, pos, neg, tag;
  // driven pins win over the outside unless a stronger driver fights them
  wire logic [3:0] gp_i = fight ? ext_i : ((gp_oe & gp_o) | (~gp_oe & ext_i));
  int errors, comparisons;

  typedef struct {logic [7:0] wr; logic rsel; logic [3:0] pad; logic [3:0] oe; logic [3:0] o; logic [2:0] roles;} adcr_row_t;
  // bits 7, 6 always written as zero
  adcr_row_t rows [5] = '{'{8'h00, 1'b0, 4'hf, 4'h0, 4'h0, 3'b101}, '{8'h2a, 1'b0, 4'h5, 4'hc, 4'h8, 3'b001},
    '{8'h15, 1'b1, 4'h8, 4'h3, 4'h1, 3'b100}, '{8'h0f, 1'b1, 4'h0, 4'h0, 4'h0, 3'b110},
    '{8'h3c, 1'b0, 4'h3, 4'hf, 4'hc, 3'b000}};

  adcr_regs #(.PART_ID(ID_VAL)) u_adcr_regs (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din),
    .dout(dout), .rdy_b(rdy_b), .conv_done(conv_done), .conv_data(conv_data), .chan_sel(chan_sel),
    .pseudo_en(pseudo_en), .status_append_enable(status_append_enable),
    .reference_source_select(reference_source_select), .gp_i(gp_i), .gp_o(gp_o), .gp_oe(gp_oe),
    .pos_input_sel(pos), .neg_input_sel(neg), .neg_input_common(ncom), .result_channel_tag(tag),
    .upper_pair_analog(upa), .lower_pair_ref2(lr2), .lower_pair_analog(lan));
  adcr_host u_adcr_host (.mclk(mclk), .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout));

  always #20 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    final_report();
  end

  initial begin
    {mclk, rst_b, conv_done, pseudo_en, status_append_enable, reference_source_select} = 6'h00;
    conv_data = 24'h000000;
    chan_sel = 8'h00;
    ext_i = 4'h0;
    fight = 1'b0;
    settle(6);
    rst_b = 1'b1;
    settle(3);
    chk(rdy_b, 1'b1, "rdy_b reset");
    chk({gp_oe, gp_o, upa, lr2, lan}, 11'h005, "pins reset");
    u_adcr_host.frame(8'h58, 24, 32'h0, rd);
    chk(rd, 32'h0, "result reset");
    u_adcr_host.frame(8'h68, 8, 32'h0, rd);
    chk(rd, 32'h0, "gpo reset");
    // a refused command followed by an aborted frame must leave the pins alone
    u_adcr_host.frame(8'ha8, 8, 32'h3f, rd);
    settle(3);
    chk(gp_oe, 4'h0, "refused write");
    u_adcr_host.frame(8'h20, 8, 32'hff, rd);
    u_adcr_host.frame(8'h60, 8, 32'h0, rd);
    chk(rd, ID_VAL, "id");
    // ==========================================================
    // ordinary output control cases
    foreach (rows[i]) begin
      reference_source_select = rows[i].rsel;
      ext_i = rows[i].pad;
      u_adcr_host.frame(8'h28, 8, rows[i].wr, rd);
      settle(3);
      chk(gp_oe, rows[i].oe, "gp_oe");
      chk(gp_o, rows[i].o, "gp_o");
      chk({upa, lr2, lan}, rows[i].roles, "roles");
      u_adcr_host.frame(8'h68, 8, 32'h0, rd);
      chk(rd, rows[i].wr, "gpo read");
    end
    // enabled pins pulled away from their drive must read back the pad, not the stored bit
    fight = 1'b1;
    ext_i = 4'h5;
    u_adcr_host.frame(8'h68, 8, 32'h0, rd);
    chk(rd, 32'h35, "gpo pad readback");
    fight = 1'b0;
    // ==========================================================
    // every positive input code; lower bits must not matter
    pseudo_en = 1'b1;
    for (int c = 0; c < 16; c++) begin
      chan_sel = {c[3:0], ~c[3:0]};
      settle(2);
      chk({pos, ncom, neg}, {c[3:0], 5'h10}, "pseudo decode");
    end
    pseudo_en = 1'b0;
    chan_sel = 8'h36;
    settle(2);
    chk({pos, ncom, neg}, 9'h066, "plain decode");
    // ==========================================================
    // conversion, appended read, then the read clears ready and the word holds
    chan_sel = 8'h9c;
    status_append_enable = 1'b1;
    conv_data = 24'ha5c3e1;
    conv_done = 1'b1;
    settle(1);
    conv_done = 1'b0;
    settle(1);
    chk({rdy_b, tag}, 5'h09, "ready and tag");
    u_adcr_host.frame(8'h58, 32, 32'h0, rd);
    chk(rd, 32'ha5c3e109, "result with status");
    settle(2);
    chk(rdy_b, 1'b1, "ready cleared");
    status_append_enable = 1'b0;
    u_adcr_host.frame(8'h58, 24, 32'h0, rd);
    chk(rd, 32'h00a5c3e1, "result again");
    // ==========================================================
    // mid-run reset with a result pending and all pins driven
    conv_done = 1'b1;
    settle(1);
    conv_done = 1'b0;
    rst_b = 1'b0;
    settle(2);
    chk({rdy_b, gp_oe, tag}, 9'h100, "reset mid-run");
    rst_b = 1'b1;
    settle(3);
    u_adcr_host.frame(8'h68, 8, 32'h0, rd);
    chk(rd, 32'h0, "gpo after reset");
    u_adcr_host.frame(8'h58, 24, 32'h0, rd);
    chk(rd, 32'h0, "result after reset");
    final_report();
  end
endmodule

`default_nettype wire
